// [ioexp_top.v]
// Serial-bus eight-pin I/O expander: slave engine, registers and pin drivers
`timescale 1ns/1ps
`default_nettype none
`include "ioexp_consts.vh"
module ioexp_top (
   input  wire       sys_clk_i,
   input  wire       rst_i,
   input  wire       scl_i,
   input  wire       sda_i,
   output reg        sda_o,
   output reg        sda_oe_n_o,
   input  wire [2:0] addr_strap_i,
   input  wire [7:0] port_pin_i,
   output reg  [7:0] high_side_driver_o,
   output reg  [7:0] low_side_driver_o,
   output reg  [7:0] port_pin_o,
   output reg  [7:0] port_pin_oe_n_o,
   output reg        alert_o,
   output reg        alert_oe_n_o
);
   // ------------------------------------------------------------------
   // State encodings
   // ------------------------------------------------------------------
   localparam [5:0] ST_IDLE = 6'b000001;
   localparam [5:0] ST_ADDR = 6'b000010;
   localparam [5:0] ST_ACK  = 6'b000100;
   localparam [5:0] ST_RX   = 6'b001000;
   localparam [5:0] ST_TX   = 6'b010000;
   localparam [5:0] ST_MACK = 6'b100000;

   wire       scl_f;
   wire       sda_f;
   reg        scl_p_q;
   reg        sda_p_q;
   reg  [5:0] state_q;
   reg  [3:0] bit_q;
   reg  [7:0] shift_q;
   reg        rd_q;
   reg        ptr_phase_q;
   reg        ack_drive_q;
   reg  [1:0] pointer_q;
   reg  [7:0] drive_level_out_q;
   reg  [7:0] input_invert_mask_q;
   reg  [7:0] pin_direction_q;
   reg  [7:0] pin_s1_q;
   reg  [7:0] pin_s2_q;
   reg  [2:0] strap_s1_q;
   reg  [2:0] strap_s2_q;
   reg  [7:0] snap_q;
   reg  [7:0] tx_byte;
   reg        sda_d;

   // ------------------------------------------------------------------
   // Line conditioning
   // ------------------------------------------------------------------
   // Limitation: each SCL phase must outlast sync plus filter, roughly six clocks,
   // since the device never stretches SCL to gain time
   // Filter both lines before any edge logic
   sync_filter u_scl (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .raw_i(scl_i), .clean_o(scl_f));
   sync_filter u_sda (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .raw_i(sda_i), .clean_o(sda_f));

   wire scl_rise = scl_f & ~scl_p_q;
   wire scl_fall = ~scl_f & scl_p_q;
   // Any SDA move while SCL high is a start or stop
   wire start_ev = scl_f & scl_p_q & sda_p_q & ~sda_f;
   wire stop_ev  = scl_f & scl_p_q & ~sda_p_q & sda_f;

   // Pins and straps come from outside, two flops each
   // Edge registers reset to the idle-high bus level, so no false edge follows reset
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         scl_p_q    <= 1'b1;
         sda_p_q    <= 1'b1;
         pin_s1_q   <= 8'h00;
         pin_s2_q   <= 8'h00;
         strap_s1_q <= 3'h0;
         strap_s2_q <= 3'h0;
      end else begin
         scl_p_q    <= scl_f;
         sda_p_q    <= sda_f;
         pin_s1_q   <= port_pin_i;
         pin_s2_q   <= pin_s1_q;
         strap_s1_q <= addr_strap_i;
         strap_s2_q <= strap_s1_q;
      end
   end

   // ------------------------------------------------------------------
   // Read data selection
   // ------------------------------------------------------------------
   // Input register is live pins through the invert mask
   // Taken once per byte at its first SCL fall; later pin moves wait for the next byte
   wire [7:0] pin_level_in = pin_s2_q ^ input_invert_mask_q;
   always @* begin
      case (pointer_q)
         `REG_PIN_LEVEL_IN:      tx_byte = pin_level_in;
         `REG_DRIVE_LEVEL_OUT:   tx_byte = drive_level_out_q;
         `REG_INPUT_INVERT_MASK: tx_byte = input_invert_mask_q;
         default:                tx_byte = pin_direction_q;
      endcase
   end

   // Straps come through their syncs; the far side holds them from start to stop
   // Address match on fixed prefix plus straps
   wire addr_hit = (shift_q[7:1] == {`ADDR_PREFIX, strap_s2_q});

   // ------------------------------------------------------------------
   // Serial slave engine
   // ------------------------------------------------------------------
   // Bits sampled on SCL rise, SDA changed on SCL fall, so SDA is steady while SCL high
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_q             <= ST_IDLE;
         bit_q               <= 4'h0;
         shift_q             <= 8'h00;
         rd_q                <= 1'b0;
         ptr_phase_q         <= 1'b0;
         ack_drive_q         <= 1'b0;
         pointer_q           <= `RST_POINTER;
         drive_level_out_q   <= `RST_DRIVE_LEVEL_OUT;
         input_invert_mask_q <= `RST_INPUT_INVERT_MASK;
         pin_direction_q     <= `RST_PIN_DIRECTION;
         sda_o               <= 1'b1;
      end else if (stop_ev) begin
         state_q     <= ST_IDLE; // pointer untouched
         ack_drive_q <= 1'b0;
      end else if (start_ev) begin
         state_q     <= ST_ADDR; // also repeated start
         bit_q       <= 4'h0;
         ack_drive_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               ack_drive_q <= 1'b0;
            end
            ST_ADDR, ST_RX: begin
               if (scl_rise) begin
                  shift_q <= {shift_q[6:0], sda_f}; // MSB first
                  bit_q   <= bit_q + 4'h1;
               end else if (scl_fall && bit_q == 4'h8) begin
                  bit_q <= 4'h0;
                  if (state_q == ST_ADDR) begin
                     if (addr_hit) begin
                        rd_q        <= shift_q[0];
                        ptr_phase_q <= ~shift_q[0];
                        ack_drive_q <= 1'b1;
                        state_q     <= ST_ACK;
                     end else begin
                        // Not ours: stay silent until the next start
                        state_q <= ST_IDLE;
                     end
                  end else begin
                     ack_drive_q <= 1'b1; // ack every byte
                     state_q     <= ST_ACK;
                     if (ptr_phase_q) begin
                        pointer_q   <= shift_q[1:0];
                        ptr_phase_q <= 1'b0;
                     end else begin
                        case (pointer_q)
                           `REG_DRIVE_LEVEL_OUT:   drive_level_out_q   <= shift_q;
                           `REG_INPUT_INVERT_MASK: input_invert_mask_q <= shift_q;
                           `REG_PIN_DIRECTION:     pin_direction_q     <= shift_q;
                           default: ; // input register ignores writes
                        endcase
                     end
                  end
               end
            end
            ST_ACK: begin
               // Hold low through ninth clock high, release on its fall
               if (scl_fall) begin
                  ack_drive_q <= 1'b0;
                  bit_q       <= 4'h0;
                  if (rd_q) begin
                     shift_q <= {tx_byte[6:0], 1'b0};
                     sda_o   <= tx_byte[7];
                     bit_q   <= 4'h1;
                     state_q <= ST_TX;
                  end else begin
                     state_q <= ST_RX;
                  end
               end
            end
            // Next bit leaves on each SCL fall; after bit 0 the line is freed
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_q == 4'h8) begin
                     sda_o   <= 1'b1; // release for master ack
                     state_q <= ST_MACK;
                  end else begin
                     sda_o   <= shift_q[7];
                     shift_q <= {shift_q[6:0], 1'b0};
                     bit_q   <= bit_q + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               // Master ack continues, NACK leaves SDA released
               if (scl_rise) begin
                  ack_drive_q <= sda_f;
               end else if (scl_fall) begin
                  if (ack_drive_q) begin
                     ack_drive_q <= 1'b0;
                     state_q     <= ST_IDLE;
                  end else begin
                     shift_q <= {tx_byte[6:0], 1'b0};
                     sda_o   <= tx_byte[7];
                     bit_q   <= 4'h1;
                     state_q <= ST_TX;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Open-drain SDA: low enable pulls line low
   always @* begin
      sda_d = 1'b1;
      if (state_q == ST_ACK && ack_drive_q)
         sda_d = 1'b0;
      else if (state_q == ST_TX)
         sda_d = sda_o;
   end
   always @(posedge sys_clk_i) begin
      if (rst_i)
         sda_oe_n_o <= 1'b1;
      else
         sda_oe_n_o <= sda_d; // drives only zero, never one
   end

   // ------------------------------------------------------------------
   // Port pin drivers
   // ------------------------------------------------------------------
   // Direction one floats the pin, zero drives one side only
   // Pin outputs reset to the register defaults, so nothing moves at release
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         high_side_driver_o <= 8'h00;
         low_side_driver_o  <= 8'h00;
         port_pin_o         <= `RST_DRIVE_LEVEL_OUT;
         port_pin_oe_n_o    <= `RST_PIN_DIRECTION;
      end else begin
         high_side_driver_o <= ~pin_direction_q & drive_level_out_q;
         low_side_driver_o  <= ~pin_direction_q & ~drive_level_out_q;
         port_pin_o         <= drive_level_out_q;
         port_pin_oe_n_o    <= pin_direction_q;
      end
   end

   // ------------------------------------------------------------------
   // Change alert
   // ------------------------------------------------------------------
   // Snapshot refreshed at input-register read ack rise or stop
   wire snap_take = stop_ev |
                    (state_q == ST_MACK && scl_rise && pointer_q == `REG_PIN_LEVEL_IN);
   wire differs   = |((pin_s2_q ^ snap_q) & pin_direction_q);
   // Read ack or stop beats a change in the same cycle, as the snapshot is retaken
   wire alert_d   = differs & ~snap_take;
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         snap_q       <= 8'h00;
         alert_o      <= 1'b0;
         alert_oe_n_o <= 1'b1;
      end else begin
         if (snap_take)
            snap_q <= pin_s2_q;
         // Clears when pins revert, since compare is live
         alert_o      <= alert_d;
         alert_oe_n_o <= ~alert_d;
      end
   end
endmodule
`default_nettype wire

// [ioexp_consts.vh]
// Constants for the eight-pin serial I/O expander
`ifndef IOEXP_CONSTS_VH
`define IOEXP_CONSTS_VH
// Register pointer values
`define REG_PIN_LEVEL_IN      2'h0
`define REG_DRIVE_LEVEL_OUT   2'h1
`define REG_INPUT_INVERT_MASK 2'h2
`define REG_PIN_DIRECTION     2'h3
// Reset values
`define RST_DRIVE_LEVEL_OUT   8'hFF
`define RST_INPUT_INVERT_MASK 8'h00
`define RST_PIN_DIRECTION     8'hFF
`define RST_POINTER           2'h0
// Fixed upper address bits, low-high-low-low
`define ADDR_PREFIX           4'h4
// Glitch filter length in system clocks
`define FILT_LEN              3'h3
`endif

// [sync_filter.v]
// Two-flop synchroniser followed by a stable-count glitch filter
`timescale 1ns/1ps
`default_nettype none
`include "ioexp_consts.vh"
module sync_filter (
   input  wire sys_clk_i,
   input  wire rst_i,
   input  wire raw_i,
   output reg  clean_o
);
   reg       s1_q;
   reg       s2_q;
   reg [2:0] cnt_q;
   // Synchroniser; first stage read only by second
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
      end else begin
         s1_q <= raw_i;
         s2_q <= s1_q;
      end
   end
   // Accept a new level only after it holds steady for a few clocks
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         cnt_q   <= 3'h0;
         clean_o <= 1'b1;
      end else if (s2_q == clean_o) begin
         cnt_q <= 3'h0;
      end else if (cnt_q == `FILT_LEN) begin
         cnt_q   <= 3'h0;
         clean_o <= s2_q;
      end else begin
         cnt_q <= cnt_q + 3'h1;
      end
   end
endmodule
`default_nettype wire

// [ioexp_checker.sv]
// Port checker for the I/O expander
`timescale 1ns/1ps
`default_nettype none
// ----
// Checker
// ----
module ioexp_checker (
   input wire logic       sys_clk_i,
   input wire logic       rst_i,
   input wire logic       scl_i,
   input wire logic       sda_oe_n_o,
   input wire logic [7:0] high_side_driver_o,
   input wire logic [7:0] low_side_driver_o,
   input wire logic [7:0] port_pin_o,
   input wire logic [7:0] port_pin_oe_n_o,
   input wire logic       alert_o,
   input wire logic       alert_oe_n_o
);
   wire [7:0] hs = high_side_driver_o;
   wire [7:0] ls = low_side_driver_o;
   wire [7:0] po = port_pin_o;
   wire [7:0] oe = port_pin_oe_n_o;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // Pin drivers follow direction and output bits
   a_input_float: assert property (((hs | ls) & oe) == 8'h00)
      else $error("driver on input pin");
   a_one_driver: assert property ((hs & ls) == 8'h00 && (hs | ls) == ~oe)
      else $error("driver count wrong");
   a_level_follow: assert property (hs == (~oe & po) && ls == (~oe & ~po))
      else $error("driver level wrong");
   a_reset_default: assert property ($fell(rst_i) |-> oe == 8'hFF && hs == 8'h00 && sda_oe_n_o)
      else $error("reset state wrong");
   a_alert_pair: assert property (alert_oe_n_o == !alert_o)
      else $error("alert line mismatch");
   // Settled clock high: no data or register change
   a_sda_hold: assert property (scl_i && $past(scl_i, 12) |-> $stable(sda_oe_n_o))
      else $error("sda moved in clock high");
   a_reg_hold: assert property (scl_i && $past(scl_i, 12) |-> $stable(po) && $stable(oe))
      else $error("register moved in clock high");
   a_ack_span: assert property ($fell(sda_oe_n_o) |-> !sda_oe_n_o [*8])
      else $error("ack too short");
   cover property ($fell(sda_oe_n_o));
   cover property ($rose(alert_o));
   cover property (hs != 8'h00);
endmodule
bind ioexp_top ioexp_checker ioexp_checker_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl_i),
   .sda_oe_n_o(sda_oe_n_o), .high_side_driver_o(high_side_driver_o), .low_side_driver_o(low_side_driver_o),
   .port_pin_o(port_pin_o), .port_pin_oe_n_o(port_pin_oe_n_o), .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o));
`default_nettype wire

// [i2c_master_model.sv]
// Serial bus master model for the expander
`timescale 1ns/1ps
`default_nettype none
// ----
// Master
// ----
module i2c_master_model (
   input  wire logic       clk_i,
   input  wire logic       sda_i,
   output var  logic       scl_o,
   output var  logic       sda_o,
   output var  logic [7:0] rd_byte_o,
   output var  int         rd_cnt_o
);
   // Quarter bit in clocks; 30 ns is too short for the input filter
   localparam int Q = 20;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      rd_byte_o = 8'h00;
      rd_cnt_o = 0;
   end
   task automatic wq;
      repeat (Q) @(posedge clk_i);
   endtask
   // Start from idle, or repeated start from clock low
   task automatic start;
      sda_o <= 1'b1;
      wq;
      scl_o <= 1'b1;
      wq;
      sda_o <= 1'b0;
      wq;
      scl_o <= 1'b0;
      wq;
   endtask
   task automatic stop;
      sda_o <= 1'b0;
      wq;
      scl_o <= 1'b1;
      wq;
      sda_o <= 1'b1;
      wq;
   endtask
   // Data moves only while the clock is low
   task automatic clk_bit(input logic b, output logic s);
      sda_o <= b;
      wq;
      scl_o <= 1'b1;
      wq;
      s = sda_i;
      wq;
      scl_o <= 1'b0;
      wq;
   endtask
   // MSB first, line released for the ack slot
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
      clk_bit(1'b1, s);
      ack = !s;
   endtask
   // Ack to continue, leave high on the last byte
   task automatic rd_byte(input logic last);
      logic [7:0] d;
      logic       s;
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
      clk_bit(last, s);
      rd_byte_o <= d;
      rd_cnt_o <= rd_cnt_o + 1;
   endtask
endmodule
`default_nettype wire

// [ioexp_top_tb.sv]
// Self-checking bench for the I/O expander
`timescale 1ns/1ps
`default_nettype none
`include "ioexp_consts.vh"
// ----
// Bench
// ----
module ioexp_top_tb;
   logic        sys_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [2:0]  strap_q = 3'h0;
   logic [7:0]  ext_q = 8'h00;
   logic [15:0] rnd_q = 16'h90D8;
   logic [7:0]  inv_e, out_e, dir_e;
   logic        a;
   wire         scl, sda_m, sda_oe_n, alert;
   wire  [7:0]  hs, ls, po, poe, rd_b;
   int          rd_cnt;
   int          miscompares = 0;
   int          checks_done = 0;
   int          rd_seen = 0;
   logic [7:0]  exp_q[$];
   // Pull-up line, open drain parties; pins see driven or outside level
   wire         sda = sda_m & sda_oe_n;
   wire  [7:0]  pins = (poe & ext_q) | (~poe & po);
   always #5 sys_clk_i = ~sys_clk_i;
   ioexp_top ioexp_top_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(),
      .sda_oe_n_o(sda_oe_n), .addr_strap_i(strap_q), .port_pin_i(pins), .high_side_driver_o(hs),
      .low_side_driver_o(ls), .port_pin_o(po), .port_pin_oe_n_o(poe), .alert_o(alert), .alert_oe_n_o());
   i2c_master_model i2c_master_model_i (.clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_m),
      .rd_byte_o(rd_b), .rd_cnt_o(rd_cnt));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Monitor takes the oldest note one clock after each read byte lands, so data is settled
   always @(posedge sys_clk_i) begin
      if (rd_cnt != rd_seen) begin
         rd_seen <= rd_cnt;
         if (exp_q.size() > 0) chk("read", exp_q.pop_front(), rd_b);
         else chk("read note", 8'h00, 8'h01);
      end
   end
   // Pointer write, data writes, then repeated start and reads
   task automatic txn(input logic wp, input logic [7:0] p, input int nw, input logic [7:0] wd,
                      input int nr, input logic [7:0] e);
      if (wp) begin
         i2c_master_model_i.start();
         i2c_master_model_i.wr_byte({`ADDR_PREFIX, strap_q, 1'b0}, a);
         chk("ack addr", 8'h01, {7'h00, a});
         i2c_master_model_i.wr_byte(p, a);
         chk("ack ptr", 8'h01, {7'h00, a});
         repeat (nw) begin
            i2c_master_model_i.wr_byte(wd, a);
            chk("ack data", 8'h01, {7'h00, a});
         end
      end
      if (nr > 0) begin
         i2c_master_model_i.start();
         i2c_master_model_i.wr_byte({`ADDR_PREFIX, strap_q, 1'b1}, a);
         chk("ack read", 8'h01, {7'h00, a});
         for (int i = 0; i < nr; i++) begin
            exp_q.push_back(e);
            i2c_master_model_i.rd_byte(i == nr - 1);
         end
      end
      i2c_master_model_i.stop();
      repeat (20) @(posedge sys_clk_i);
   endtask
   // Main sequence; straps held for the whole run
   initial begin
      repeat (8) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      strap_q <= rnd_q[2:0];
      ext_q <= rnd_q[15:8];
      repeat (20) @(posedge sys_clk_i);
      chk("dir pins", 8'hFF, poe);
      chk("drivers", 8'h00, hs | ls);
      txn(1'b1, 8'h01, 0, 8'h00, 1, 8'hFF);
      txn(1'b1, 8'h02, 0, 8'h00, 1, 8'h00);
      txn(1'b1, 8'h03, 0, 8'h00, 1, 8'hFF);
      chk("alert idle", 8'h00, {7'h00, alert});
      ext_q <= ext_q ^ 8'h10;
      repeat (20) @(posedge sys_clk_i);
      chk("alert set", 8'h01, {7'h00, alert});
      txn(1'b1, 8'h00, 1, 8'h5A, 1, ext_q);
      chk("alert clr", 8'h00, {7'h00, alert});
      $display("test reset and alert done");
      rnd_q = lfsr(rnd_q);
      inv_e = rnd_q[7:0];
      txn(1'b1, 8'h02, 1, inv_e, 0, 8'h00);
      txn(1'b1, 8'h00, 0, 8'h00, 2, ext_q ^ inv_e);
      txn(1'b1, 8'hFE, 0, 8'h00, 1, inv_e);
      txn(1'b1, 8'h02, 1, 8'h00, 0, 8'h00);
      $display("test invert done");
      rnd_q = lfsr(rnd_q);
      out_e = rnd_q[7:0];
      dir_e = rnd_q[15:8];
      txn(1'b1, 8'h03, 1, dir_e, 0, 8'h00);
      txn(1'b1, 8'h01, 2, out_e, 0, 8'h00);
      txn(1'b1, 8'h03, 0, 8'h00, 1, dir_e);
      txn(1'b0, 8'h00, 0, 8'h00, 1, dir_e);
      txn(1'b1, 8'h01, 0, 8'h00, 1, out_e);
      txn(1'b1, 8'h00, 0, 8'h00, 1, (dir_e & ext_q) | (~dir_e & out_e));
      chk("high drv", ~dir_e & out_e, hs);
      chk("low drv", ~dir_e & ~out_e, ls);
      chk("pin oe", dir_e, poe);
      i2c_master_model_i.start();
      i2c_master_model_i.wr_byte({`ADDR_PREFIX, ~strap_q, 1'b0}, a);
      chk("ack other", 8'h00, {7'h00, a});
      i2c_master_model_i.stop();
      $display("test pins and address done");
      // Mid-run reset: registers, drivers and pointer back to defaults
      rst_i <= 1'b1;
      repeat (8) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      repeat (20) @(posedge sys_clk_i);
      chk("reset dir", 8'hFF, poe);
      chk("reset drv", 8'h00, hs | ls);
      txn(1'b0, 8'h00, 0, 8'h00, 1, ext_q);
      txn(1'b1, 8'h01, 0, 8'h00, 1, 8'hFF);
      $display("test mid-run reset done");
      results();
   end
   // Hang guard
   initial begin
      repeat (95000) @(posedge sys_clk_i);
      miscompares++;
      $display("MISMATCH run exp end got hang");
      results();
   end
endmodule
`default_nettype wire
